// *** design/cdwr_pkg.sv ***
// Constants shared by the countdown watchdog design.
// Assumes a 200 MHz core clock and an 8-bit register port.
package cdwr_pkg;

    localparam int          CDWR_ADDR_W         = 8;
    localparam int          CDWR_DATA_W         = 8;
    localparam int          CDWR_CNT_W          = 7;

    // Register map
    localparam logic [7:0]  CDWR_CTRL_OFS       = 8'h08;
    localparam logic [7:0]  CDWR_CTRL_RST       = 8'h7f;
    localparam int          CDWR_ACT_BIT        = 7;
    localparam int          CDWR_TOP_BIT        = 6;

    // Decrement period in machine cycles
    localparam int          CDWR_PRESCALE       = 49152;
    localparam int          CDWR_PRE_W          = 16;

    // Reset pulse length
    localparam int          CDWR_PULSE_NS       = 500;
    localparam int          CDWR_CLK_PERIOD_NS  = 5;
    localparam int          CDWR_PULSE_CYC      = CDWR_PULSE_NS / CDWR_CLK_PERIOD_NS;
    localparam int          CDWR_PULSE_W        = 8;

endpackage

// *** design/cdwr_pulse_gen.sv ***
// Fixed-length active-low pulse generator.
// Assumes trigger is a one-cycle strobe on the same clock.
`timescale 1ns/1ps
module cdwr_pulse_gen #(
    parameter int LEN = 100,
    parameter int W   = 8
) (
    input  wire logic clk_i,     // Clock
    input  wire logic rst_n_i,   // Synchronised reset, active low
    input  wire logic trig_i,    // Start a pulse
    output logic      pulse_n_o  // Registered pulse, active low
);

    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic         pulse_n_r;
    logic         pulse_n_nxt;

    always_comb begin
        cnt_nxt     = cnt_r;
        pulse_n_nxt = 1'b1;
        if (trig_i) begin
            cnt_nxt     = W'(LEN - 1);
            pulse_n_nxt = 1'b0;
        end else if (cnt_r != '0) begin
            cnt_nxt     = cnt_r - 1'b1;
            pulse_n_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r     <= '0;
            pulse_n_r <= 1'b1;
        end else begin
            cnt_r     <= cnt_nxt;
            pulse_n_r <= pulse_n_nxt;
        end
    end

    assign pulse_n_o = pulse_n_r;

endmodule

// *** design/cdwr_watchdog.sv ***
// Countdown watchdog that pulls the device reset low on expiry.
// Assumes a simple register port with single-cycle strobes; one clock.
// The reset output is not fed back here; the device reset tree must do it.
// PRESCALE may be shortened for simulation; its default is the real period.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Operation
// - Decrement countdown every 49152 cycles
// - Timeout programmable in 64 steps
// - Active and 40h to 3Fh: reset pulse
// - Disabled after reset; writes cannot disable
// - Write activating with top clear: reset
// - Activate bit set by software only
// - Bits 6:0 hold readable writable countdown
// - Control resets to 7Fh
module cdwr_watchdog
    import cdwr_pkg::*;
#(
    parameter int PRESCALE = cdwr_pkg::CDWR_PRESCALE
) (
    input  wire logic                            core_clk_i,  // 200 MHz clock
    input  wire logic                            reset_n_i,   // Async reset, active low
    input  wire logic [cdwr_pkg::CDWR_ADDR_W-1:0] addr_i,      // Register address
    input  wire logic [cdwr_pkg::CDWR_DATA_W-1:0] wdata_i,     // Write data
    input  wire logic                            wr_i,        // Write strobe
    input  wire logic                            rd_i,        // Read strobe
    output logic      [cdwr_pkg::CDWR_DATA_W-1:0] rdata_o,     // Read data, next cycle
    output logic                                 wdg_rst_n_o  // Reset request, active low
);
    import cdwr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release
    logic rst_meta_r;
    logic rst_meta_nxt;
    logic rst_n_r;
    logic rst_n_nxt;

    // Only the second stage is read; the first may settle late on release
    always_comb begin
        rst_meta_nxt = 1'b1;
        rst_n_nxt    = rst_meta_r;
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= rst_meta_nxt;
            rst_n_r    <= rst_n_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register decode; fields of a control write
    logic                  ctrl_wr;
    logic                  wr_act;
    logic                  wr_top;
    logic [CDWR_CNT_W-1:0] wr_cnt;

    assign ctrl_wr = wr_i && (addr_i == CDWR_CTRL_OFS);
    assign wr_act  = wdata_i[CDWR_ACT_BIT];
    assign wr_top  = wdata_i[CDWR_TOP_BIT];
    assign wr_cnt  = wdata_i[CDWR_CNT_W-1:0];

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler; one tick closes each decrement period
    // PRESCALE must fit the prescaler width
    logic [CDWR_PRE_W-1:0] pre_r;
    logic [CDWR_PRE_W-1:0] pre_nxt;
    logic                  tick;

    assign tick = (pre_r == CDWR_PRE_W'(PRESCALE - 1));

    always_comb begin
        pre_nxt = pre_r + 1'b1;
        if (ctrl_wr || tick) begin
            // Restart on a write so a refresh always buys whole steps
            pre_nxt = '0;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Activation state; only a reset leaves the on state
    typedef enum logic [1:0] {
        CDWR_ACT_OFF = 2'b01,
        CDWR_ACT_ON  = 2'b10
    } cdwr_act_state_e;

    cdwr_act_state_e act_st_r;
    cdwr_act_state_e act_st_nxt;
    logic            act_on;
    logic            act_on_nxt;

    always_comb begin
        act_st_nxt = act_st_r;
        case (act_st_r)
            CDWR_ACT_OFF: begin
                if (ctrl_wr && wr_act) begin
                    act_st_nxt = CDWR_ACT_ON;
                end
            end
            CDWR_ACT_ON: begin
                // A zero written to the activation bit is ignored
                act_st_nxt = CDWR_ACT_ON;
            end
            default: begin
                // A corrupt code stays armed rather than silently disarm
                act_st_nxt = CDWR_ACT_ON;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            // Start state follows the reset value of the activation bit
            act_st_r <= CDWR_CTRL_RST[CDWR_ACT_BIT] ? CDWR_ACT_ON
                                                    : CDWR_ACT_OFF;
        end else begin
            act_st_r <= act_st_nxt;
        end
    end

    assign act_on     = (act_st_r == CDWR_ACT_ON);
    assign act_on_nxt = (act_st_nxt == CDWR_ACT_ON);

    ////////////////////////////////////////////////////////////////////////////
    // Countdown; a write wins over a tick in the same cycle
    logic [CDWR_CNT_W-1:0] cnt_r;
    logic [CDWR_CNT_W-1:0] cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        if (ctrl_wr) begin
            cnt_nxt = wr_cnt;
        end else if (tick) begin
            // Wraps from 00h to 7Fh while disabled
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cnt_r <= CDWR_CTRL_RST[CDWR_CNT_W-1:0];
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset triggers
    logic expire;
    logic soft_fire;
    logic fire;

    // Expiry on the 40h to 3Fh roll only; a refresh that cycle saves it
    assign expire    = act_on && tick && !ctrl_wr && (cnt_r == 7'h40);

    // Activated with the top bit clear, also when already active
    assign soft_fire = ctrl_wr && act_on_nxt && !wr_top;
    assign fire      = expire || soft_fire;

    ////////////////////////////////////////////////////////////////////////////
    // Reset pulse; the only effect on the rest of the device
    // A new trigger during a pulse restarts its length
    cdwr_pulse_gen #(
        .LEN (CDWR_PULSE_CYC),
        .W   (CDWR_PULSE_W)
    ) u_pulse (
        .clk_i     (core_clk_i),
        .rst_n_i   (rst_n_r),
        .trig_i    (fire),
        .pulse_n_o (wdg_rst_n_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read port; unmapped addresses read zero
    logic [CDWR_DATA_W-1:0] rdata_r;
    logic [CDWR_DATA_W-1:0] rdata_nxt;

    always_comb begin
        rdata_nxt = '0;
        if (rd_i) begin
            case (addr_i)
                CDWR_CTRL_OFS: begin
                    rdata_nxt = {act_on, cnt_r};
                end
                default: begin
                    rdata_nxt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata_o = rdata_r;

endmodule

// *** tb/cdwr_watchdog_sva.sv ***
// Port checker for the countdown watchdog.
// Assumes the bench runs it with PRESCALE of 8.
`timescale 1ns/1ps
module cdwr_watchdog_sva #(
    parameter int PRESCALE = 8
) (
    input wire logic       core_clk_i, // clk
    input wire logic       reset_n_i,  // rst
    input wire logic [7:0] addr_i,     // addr
    input wire logic [7:0] wdata_i,    // wdata
    input wire logic       wr_i,       // wr
    input wire logic       rd_i,       // rd
    input wire logic [7:0] rdata_o,    // rdata
    input wire logic       wdg_rst_n_o // reset out
);
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    wire w = wr_i && addr_i == 8'h08;
    wire r = rd_i && addr_i == 8'h08;
    // Idle span is two decrement periods at PRESCALE 8
    sequence s_arm;
        w && wdata_i == 8'hc1;
    endsequence
    sequence s_idle;
        !wr_i [*8] ##1 !wr_i [*8];
    endsequence
    chk_rd_idle: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("rdata not idle");
    chk_rd_unmap: assert property (rd_i && !r |=> rdata_o == 8'h00)
        else $error("unmapped read");
    chk_rd_back: assert property (w ##2 r |=> rdata_o[6:0] == $past(wdata_i[6:0], 3))
        else $error("readback");
    chk_act_sticky: assert property (w && wdata_i[7] ##2 w ##2 r |=> rdata_o[7])
        else $error("activation lost");
    chk_fire_now: assert property (w && wdata_i[7:6] == 2'b10 |=> !wdg_rst_n_o)
        else $error("no soft reset");
    chk_no_fire: assert property (w && wdata_i[6] && wdg_rst_n_o |=> wdg_rst_n_o)
        else $error("refresh fired");
    chk_tick_fire: assert property (s_arm ##1 s_idle |=> !wdg_rst_n_o)
        else $error("expiry missed");
    chk_pulse_len: assert property ($fell(wdg_rst_n_o) |-> ##99 !wdg_rst_n_o ##1 wdg_rst_n_o)
        else $error("pulse length");
endmodule
bind cdwr_watchdog cdwr_watchdog_sva #(.PRESCALE(PRESCALE)) u_sva (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .wdg_rst_n_o(wdg_rst_n_o));

// *** tb/tb_countdown_watchdog_reset.sv ***
// Self-checking bench for the countdown watchdog.
// Assumes PRESCALE 8 so one decrement takes 8 cycles.
`timescale 1ns/1ps
module tb_countdown_watchdog_reset;
    logic       clk = 0, rst_n = 0, wr = 0, rd = 0, wdg_n;
    logic [7:0] addr = 0, wd = 0, rdat, v;
    int         err_total = 0, total_checks = 0, cyc = 0, n, k;
    cdwr_watchdog #(.PRESCALE(8)) dut (.core_clk_i(clk), .reset_n_i(rst_n), .addr_i(addr),
        .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdat), .wdg_rst_n_o(wdg_n));
    initial forever #2.5 clk = ~clk;
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            err_total++;
            finish_test();
        end
    end
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One strobe cycle; returns just after the edge that took it
    task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wd <= d;
        @(posedge clk);
        wr <= 0;
        rd <= 0;
        #1;
    endtask
    // Counts cycles while the reset output keeps one level, capped at 200
    task automatic run(logic lvl);
        n = 0;
        while (wdg_n === lvl && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask
    task automatic do_reset();
        @(posedge clk);
        rst_n <= 0;
        repeat (5) @(posedge clk);
        rst_n <= 1;
        repeat (3) @(posedge clk);
    endtask
    function automatic logic [7:0] exp_cnt(logic [7:0] s, int d);
        return (s - 8'(d)) & 8'h7f;
    endfunction
    ////////////////////////////////////////
    initial begin
        n = $urandom(12138);
        do_reset();
        acc(0, 8'h08, 8'h00);
        chk("ctrl reset", 8'h7f, rdat);
        acc(1, 8'h09, 8'h55);
        acc(0, 8'h09, 8'h00);
        chk("unmapped", 8'h00, rdat);
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 8'h01 : 8'($urandom) & 8'h7f;
            k = $urandom % 3;
            acc(1, 8'h08, v);
            repeat (8 * k + 2) @(posedge clk);
            acc(0, 8'h08, 8'h00);
            chk("countdown", exp_cnt(v, k), rdat);
            chk("inactive", 8'h01, {7'h00, wdg_n});
        end
        acc(1, 8'h08, 8'hc1);
        run(1'b1);
        chk("expiry", 8'h10, 8'(n));
        run(1'b0);
        chk("pulse", 8'h64, 8'(n));
        acc(1, 8'h08, 8'hc5);
        acc(1, 8'h08, 8'h7f);
        acc(0, 8'h08, 8'h00);
        chk("sticky", 8'hff, rdat);
        for (int j = 0; j < 4; j++) begin
            acc(1, 8'h08, 8'hc1 | (8'($urandom) & 8'h3f));
            repeat (12) @(posedge clk);
            chk("refresh", 8'h01, {7'h00, wdg_n});
        end
        acc(1, 8'h08, 8'h3f);
        run(1'b1);
        chk("soft fire", 8'h00, 8'(n));
        run(1'b0);
        do_reset();
        acc(1, 8'h08, 8'h3f);
        run(1'b1);
        chk("disabled", 8'hc8, 8'(n));
        acc(1, 8'h08, 8'h80);
        run(1'b1);
        chk("arm fire", 8'h00, 8'(n));
        finish_test();
    end
endmodule
